// ===== afb_status_framer.sv
// Periodic status feedback frame builder with error flags and AXI4-Lite registers.
//
// Contract
// - Send status frame every 100 ms unprompted.
// - Identifier 0x19EFFF plus source address byte.
// - Bytes 0-1 carry measured position.
// - Bytes 2-3 carry measured motor current.
// - Byte 4 carries measured speed.
// - Byte 6 holds extend, retract, saturated flags.
// - Byte 7 errors; byte 5 factory reserved.
// - Bad command value sets bit 0, blocks motion.
// - Current over limit 15 ms sets bit 1.
// - After overload, wait for enable cleared.
// - Voltage error bit 2, 10 s continuation.
// - Temperature error bit 3, same continuation.
// - Uncommanded movement sets bit 4.
// - No command within timeout sets bit 5.
// - No motion while driving sets bit 6.
// - Memory corruption sets bit 7.
// - Address is 19 plus three select inputs.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
module afb_status_framer
  import afb_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = afb_pkg::PERIOD_CYC,
  parameter int unsigned OVL_CYCLES = afb_pkg::OVL_CYC,
  parameter int unsigned MS_CYCLES = afb_pkg::CYC_PER_MS
) (
  input wire logic aclk, // System clock, 100 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte enables.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [15:0] meas_pos, // Position, 0.1 mm per count.
  input wire logic [15:0] meas_cur, // Motor current, 0.1 A per count.
  input wire logic [7:0] meas_speed, // Speed, 1 mm/s per count.
  input wire logic mv_extend, // Actuator extending.
  input wire logic mv_retract, // Actuator retracting.
  input wire logic mv_saturated, // Moving at the highest reachable speed.
  input wire logic motor_driving, // Motor powered past its start phase.
  input wire logic cmd_rx, // Pulse: motion command frame received.
  input wire logic cmd_enable, // Motion enable bit of that frame.
  input wire logic [15:0] cmd_cur_limit, // Current limit of that frame.
  input wire logic cmd_range_bad, // A value of that frame is out of range.
  input wire logic backdrive_evt, // Pulse: uncommanded tube movement.
  input wire logic stall_evt, // Pulse: driving gave no motion.
  input wire logic mem_bad_evt, // Pulse: internal memory corrupted.
  input wire logic volt_ok_pin, // Supply voltage within range.
  input wire logic temp_ok_pin, // Temperature within range.
  input wire logic [2:0] addr_sel_pin, // Address select 3..1.
  output logic motion_permit, // New motion may start.
  output logic motion_halt, // Stop the motion in progress.
  output logic [28:0] tx_id, // Frame identifier.
  output logic [7:0] tx_data, // Frame byte.
  output logic tx_valid, // Frame byte valid.
  output logic tx_last, // Last byte of the frame.
  input wire logic tx_ready // CAN controller takes the byte.
);
  // Pin synchroniser: {addr_sel, temp_ok, volt_ok}.
  logic [4:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg, pin_next;
  logic [7:0] node_reg, node_next;
  always_comb
  begin
    pin_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg)) | (pin_reg & (pin_s2_reg ^ pin_s3_reg));
    node_next = NODE_ADDR_BASE + {5'h00, pin_reg[4:2]};
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_reg <= 5'h03;
      pin_s2_reg <= 5'h03;
      pin_s3_reg <= 5'h03;
      pin_reg <= 5'h03;
      node_reg <= NODE_ADDR_BASE;
    end
    else
    begin
      pin_s1_reg <= {addr_sel_pin, temp_ok_pin, volt_ok_pin};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg <= pin_next;
      node_reg <= node_next;
    end
  end

  // Register bus state.
  logic awready_reg, awready_next, bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next, count_reg;
  logic tx_en_reg, tx_en_next;
  logic [15:0] tmo_reg, tmo_next;
  logic [7:0] err_clr;
  logic [7:0] err_reg;
  logic rearm_reg, permit_reg, halt_reg;
  logic wr_go;
  always_comb
  begin
    wr_go = awready_reg && s_axi_awvalid && s_axi_wvalid;
    awready_next = s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
    bvalid_next = wr_go || (bvalid_reg && !s_axi_bready);
    bresp_next = bresp_reg;
    tx_en_next = tx_en_reg;
    tmo_next = tmo_reg;
    err_clr = 8'h00;
    if (wr_go)
    begin
      bresp_next = RESP_OKAY;
      unique case (s_axi_awaddr)
        CTRL_OFS: tx_en_next = s_axi_wstrb[0] ? s_axi_wdata[CTRL_TX_EN_BIT] : tx_en_reg;
        TIMEOUT_OFS:
        begin
          tmo_next[7:0] = s_axi_wstrb[0] ? s_axi_wdata[7:0] : tmo_reg[7:0];
          tmo_next[15:8] = s_axi_wstrb[1] ? s_axi_wdata[15:8] : tmo_reg[15:8];
        end
        ERR_CLR_OFS: err_clr = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        STATUS_OFS, NODE_OFS, COUNT_OFS: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    arready_next = s_axi_arvalid && !arready_reg && !rvalid_reg;
    rvalid_next = (arready_reg && s_axi_arvalid) || (rvalid_reg && !s_axi_rready);
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (arready_reg && s_axi_arvalid)
    begin
      rresp_next = RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFS: rdata_next = {31'h00000000, tx_en_reg};
        TIMEOUT_OFS: rdata_next = {16'h0000, tmo_reg};
        STATUS_OFS: rdata_next = {13'h0000, halt_reg, rearm_reg, permit_reg, 5'h00,
                                  mv_saturated, mv_retract, mv_extend, err_reg};
        NODE_OFS: rdata_next = {24'h000000, node_reg};
        COUNT_OFS: rdata_next = count_reg;
        ERR_CLR_OFS: rdata_next = 32'h00000000;
        default:
        begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
      tx_en_reg <= CTRL_TX_EN_RST;
      tmo_reg <= TIMEOUT_MS_RST;
    end
    else
    begin
      awready_reg <= awready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      tx_en_reg <= tx_en_next;
      tmo_reg <= tmo_next;
    end
  end

  // Error flags, timers and motion gating.
  logic [31:0] ovl_cnt_reg, ovl_cnt_next, ms_cnt_reg, ms_cnt_next;
  logic [15:0] idle_ms_reg, idle_ms_next, cont_ms_reg, cont_ms_next, lim_reg, lim_next;
  logic [7:0] err_next;
  logic rearm_next, permit_next, halt_next, en_reg, en_next;
  logic ms_tick, over_lim, ovl_set, moving, env_bad;
  always_comb
  begin
    ms_tick = ms_cnt_reg == MS_CYCLES - 1;
    ms_cnt_next = ms_tick ? 32'h00000000 : ms_cnt_reg + 32'h00000001;
    lim_next = cmd_rx ? cmd_cur_limit : lim_reg;
    en_next = cmd_rx ? cmd_enable : en_reg;
    moving = mv_extend || mv_retract;
    over_lim = motor_driving && (meas_cur > lim_reg);
    ovl_cnt_next = over_lim ? ((ovl_cnt_reg == OVL_CYCLES) ? ovl_cnt_reg : ovl_cnt_reg + 32'h00000001) : 32'h00000000;
    ovl_set = over_lim && (ovl_cnt_reg == OVL_CYCLES - 1);
    idle_ms_next = cmd_rx ? 16'h0000 : ((ms_tick && idle_ms_reg != 16'hffff) ? idle_ms_reg + 16'h0001 : idle_ms_reg);
    env_bad = !pin_reg[0] || !pin_reg[1];
    cont_ms_next = (env_bad && moving) ? ((ms_tick && cont_ms_reg < CONT_MS[15:0]) ? cont_ms_reg + 16'h0001 : cont_ms_reg)
                                       : 16'h0000;
    // Clearing the enable bit releases the overload and stall lock; a new event wins.
    rearm_next = ovl_set || stall_evt || (rearm_reg && !(cmd_rx && !cmd_enable));
    err_next[ERR_PARAM] = (cmd_rx && cmd_range_bad) || (err_reg[ERR_PARAM] && !err_clr[ERR_PARAM]);
    err_next[ERR_OVL] = ovl_set || (err_reg[ERR_OVL] && rearm_next);
    err_next[ERR_VOLT] = !pin_reg[0];
    err_next[ERR_TEMP] = !pin_reg[1];
    err_next[ERR_BACK] = backdrive_evt || (err_reg[ERR_BACK] && !err_clr[ERR_BACK]);
    err_next[ERR_TMO] = !cmd_rx && (idle_ms_reg >= tmo_reg);
    err_next[ERR_STALL] = stall_evt || (err_reg[ERR_STALL] && rearm_next);
    err_next[ERR_MEM] = mem_bad_evt || (err_reg[ERR_MEM] && !err_clr[ERR_MEM]);
    permit_next = en_reg && !err_reg[ERR_PARAM] && !rearm_reg && !env_bad;
    halt_next = moving && (err_reg[ERR_PARAM] || rearm_reg || cont_ms_reg >= CONT_MS[15:0]);
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovl_cnt_reg <= 32'h00000000;
      ms_cnt_reg <= 32'h00000000;
      idle_ms_reg <= 16'h0000;
      cont_ms_reg <= 16'h0000;
      lim_reg <= 16'h0000;
      en_reg <= 1'b0;
      err_reg <= 8'h00;
      rearm_reg <= 1'b0;
      permit_reg <= 1'b0;
      halt_reg <= 1'b0;
    end
    else
    begin
      ovl_cnt_reg <= ovl_cnt_next;
      ms_cnt_reg <= ms_cnt_next;
      idle_ms_reg <= idle_ms_next;
      cont_ms_reg <= cont_ms_next;
      lim_reg <= lim_next;
      en_reg <= en_next;
      err_reg <= err_next;
      rearm_reg <= rearm_next;
      permit_reg <= permit_next;
      halt_reg <= halt_next;
    end
  end

  // Frame timing and byte transmitter.
  afb_tx_state_t tx_state_reg, tx_state_next;
  logic [31:0] per_cnt_reg, per_cnt_next, count_next;
  logic [2:0] idx_reg, idx_next;
  logic [28:0] id_reg, id_next;
  logic valid_reg, valid_next, last_reg, last_next, load, rd_en, per_tick;
  logic [63:0] snap;
  always_comb
  begin
    per_tick = per_cnt_reg == PERIOD_CYCLES - 1;
    per_cnt_next = per_tick ? 32'h00000000 : per_cnt_reg + 32'h00000001;
    snap = {err_reg, {5'h00, mv_saturated, mv_retract, mv_extend}, FACTORY_BYTE, meas_speed,
            meas_cur[15:8], meas_cur[7:0], meas_pos[15:8], meas_pos[7:0]};
    tx_state_next = tx_state_reg;
    idx_next = idx_reg;
    id_next = id_reg;
    valid_next = valid_reg;
    last_next = last_reg;
    count_next = count_reg;
    load = 1'b0;
    rd_en = 1'b0;
    unique case (tx_state_reg)
      TX_IDLE:
      begin
        if (per_tick && tx_en_reg)
        begin
          load = 1'b1;
          id_next = {ID_HIGH, node_reg};
          idx_next = 3'h0;
          tx_state_next = TX_FETCH;
        end
      end
      TX_FETCH:
      begin
        rd_en = 1'b1;
        valid_next = 1'b1;
        last_next = idx_reg == LAST_BYTE;
        tx_state_next = TX_SEND;
      end
      TX_SEND:
      begin
        if (tx_ready)
        begin
          valid_next = 1'b0;
          last_next = 1'b0;
          idx_next = idx_reg + 3'h1;
          tx_state_next = last_reg ? TX_IDLE : TX_FETCH;
          count_next = last_reg ? count_reg + 32'h00000001 : count_reg;
        end
      end
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state_reg <= TX_IDLE;
      per_cnt_reg <= 32'h00000000;
      idx_reg <= 3'h0;
      id_reg <= {ID_HIGH, NODE_ADDR_BASE};
      valid_reg <= 1'b0;
      last_reg <= 1'b0;
      count_reg <= 32'h00000000;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      per_cnt_reg <= per_cnt_next;
      idx_reg <= idx_next;
      id_reg <= id_next;
      valid_reg <= valid_next;
      last_reg <= last_next;
      count_reg <= count_next;
    end
  end

  // Frame snapshot store with registered byte output.
  afb_frame_buf u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(load),
    .load_data(snap),
    .rd_en(rd_en),
    .rd_idx(idx_reg),
    .rd_data(tx_data)
  );

  // Outputs, each taken from a flip-flop.
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = awready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign motion_permit = permit_reg;
  assign motion_halt = halt_reg;
  assign tx_id = id_reg;
  assign tx_valid = valid_reg;
  assign tx_last = last_reg;
endmodule

// ===== afb_pkg.sv
// Constants, register map and field layout of the status feedback framer.
package afb_pkg;
  // Clock rate and derived timing counts.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned PERIOD_MS = 100;
  localparam int unsigned PERIOD_CYC = CYC_PER_MS * PERIOD_MS;
  localparam int unsigned OVL_MS = 15;
  localparam int unsigned OVL_CYC = CYC_PER_MS * OVL_MS;
  localparam int unsigned CONT_S = 10;
  localparam int unsigned CONT_MS = CONT_S * 1000;
  localparam logic [15:0] TIMEOUT_MS_RST = 16'h1388;
  // Node address and frame identifier layout.
  localparam logic [7:0] NODE_ADDR_BASE = 8'h13;
  localparam logic [20:0] ID_HIGH = 21'h19efff;
  localparam logic [7:0] FACTORY_BYTE = 8'h00;
  localparam logic [2:0] LAST_BYTE = 3'h7;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIMEOUT_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] NODE_OFS = 8'h0c;
  localparam logic [7:0] COUNT_OFS = 8'h10;
  localparam logic [7:0] ERR_CLR_OFS = 8'h14;
  // Control register fields and reset values.
  localparam int unsigned CTRL_TX_EN_BIT = 0;
  localparam logic CTRL_TX_EN_RST = 1'b1;
  // Error flag positions inside frame byte 7.
  localparam int unsigned ERR_PARAM = 0;
  localparam int unsigned ERR_OVL = 1;
  localparam int unsigned ERR_VOLT = 2;
  localparam int unsigned ERR_TEMP = 3;
  localparam int unsigned ERR_BACK = 4;
  localparam int unsigned ERR_TMO = 5;
  localparam int unsigned ERR_STALL = 6;
  localparam int unsigned ERR_MEM = 7;
  // Status register fields.
  localparam int unsigned ST_MOTION_LSB = 8;
  localparam int unsigned ST_PERMIT_BIT = 16;
  localparam int unsigned ST_REARM_BIT = 17;
  localparam int unsigned ST_HALT_BIT = 18;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_SEND} afb_tx_state_t;
endpackage

// ===== afb_frame_buf.sv
// Eight-byte frame buffer loaded whole and read one byte at a time.
module afb_frame_buf (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic load, // Capture all eight bytes at once.
  input wire logic [63:0] load_data, // Byte 0 in the low bits.
  input wire logic rd_en, // Read the byte at rd_idx.
  input wire logic [2:0] rd_idx, // Byte index.
  output logic [7:0] rd_data // Registered read data.
);
  logic [7:0] mem_reg [8];
  logic [7:0] mem_next [8];
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;

  // Whole-frame load keeps the snapshot coherent; reads hold when idle.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      mem_next[i] = load ? load_data[8*i +: 8] : mem_reg[i];
    end
    rd_data_next = rd_en ? mem_reg[rd_idx] : rd_data_reg;
  end

  // Registers for the buffer.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 8; i++)
      begin
        mem_reg[i] <= 8'h00;
      end
      rd_data_reg <= 8'h00;
    end
    else
    begin
      mem_reg <= mem_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
endmodule

// ===== afb_status_framer_properties.sv
// Port checker for the status feedback framer, bound to the framer top.
module afb_status_framer_chk (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic stall_evt, // Driving gave no motion.
  input wire logic volt_ok_pin, // Supply in range.
  input wire logic motion_permit, // New motion may start.
  input wire logic [28:0] tx_id, // Frame identifier.
  input wire logic [7:0] tx_data, // Frame byte.
  input wire logic tx_valid, // Frame byte valid.
  input wire logic tx_last, // Last frame byte.
  input wire logic tx_ready // Byte taken.
);
  logic [2:0] bidx_reg; // Index of the byte on offer.
  logic [2:0] bidx_next; // Next byte index.
  // Step the index on each taken byte, back to zero after the last.
  always_comb
  begin
    bidx_next = bidx_reg;
    if (tx_valid && tx_ready)
    begin
      bidx_next = tx_last ? 3'h0 : bidx_reg + 3'h1;
    end
  end
  // Register the byte index.
  always_ff @(posedge aclk)
  begin
    bidx_reg <= aresetn ? bidx_next : 3'h0;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_accept; tx_valid && tx_ready; endsequence
  sequence s_wr_taken; s_axi_awready && s_axi_wready; endsequence
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last) && $stable(tx_id);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("frame byte changed before it was taken");
  property p_tx_gap; s_accept |=> !tx_valid; endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("no idle cycle after a taken byte");
  property p_id; tx_valid |-> tx_id[28:8] == 21'h19efff && tx_id[7:0] >= 8'h13 && tx_id[7:0] <= 8'h1a; endproperty
  a_id: assert property (p_id) else $error("identifier out of the expected set");
  property p_fact; tx_valid && bidx_reg == 3'h5 |-> tx_data == 8'h00; endproperty
  a_fact: assert property (p_fact) else $error("factory byte not zero");
  property p_last; tx_valid |-> tx_last == (bidx_reg == 3'h7); endproperty
  a_last: assert property (p_last) else $error("last flag not on the eighth byte");
  property p_wr; s_wr_taken |=> s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write response late");
  property p_rd; s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read data late");
  property p_stall; stall_evt |-> ##3 !motion_permit; endproperty
  a_stall: assert property (p_stall) else $error("motion permitted after a stall");
  property p_volt; !volt_ok_pin [*8] |-> !motion_permit; endproperty
  a_volt: assert property (p_volt) else $error("motion permitted with supply out of range");
endmodule
bind afb_status_framer afb_status_framer_chk afb_status_framer_chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .stall_evt(stall_evt), .volt_ok_pin(volt_ok_pin),
  .motion_permit(motion_permit), .tx_id(tx_id), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
  .tx_ready(tx_ready));

// ===== afb_can_sink.sv
// Model of the CAN controller that takes frame bytes at a random pace.
module afb_can_sink (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic [28:0] tx_id, // Identifier offered.
  input wire logic [7:0] tx_data, // Byte offered.
  input wire logic tx_valid, // Byte valid.
  input wire logic tx_last, // Last byte.
  output logic tx_ready, // Byte taken.
  output logic [63:0] frame, // Last whole frame, byte 0 low.
  output logic [28:0] fid, // Identifier of that frame.
  output int frames, // Frames taken.
  output int per // Cycles between the last two frame starts.
);
  int cyc_cnt;
  int t0;
  logic [2:0] idx;
  logic v_q;
  // Stall at random and assemble bytes in arrival order.
  always @(posedge aclk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    v_q <= tx_valid;
    tx_ready <= ($urandom_range(3) != 0);
    if (!aresetn)
    begin
      idx <= 3'h0;
      frames <= 0;
      cyc_cnt <= 0;
      t0 <= 0;
      per <= 0;
    end
    else
    begin
      if (tx_valid && !v_q && idx == 3'h0)
      begin
        per <= cyc_cnt - t0;
        t0 <= cyc_cnt;
      end
      if (tx_valid && tx_ready)
      begin
        frame[idx*8 +: 8] <= tx_data;
        idx <= tx_last ? 3'h0 : idx + 3'h1;
        if (tx_last)
        begin
          fid <= tx_id;
          frames <= frames + 1;
        end
      end
    end
  end
endmodule

// ===== tb_afb_status_framer.sv
// Self-checking bench of the status feedback framer.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_afb_status_framer;
  import afb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic awr, wr_r, bv, arr, rv, permit, halt, tvalid, tlast, trdy, mdrv = 1'b0, crx = 1'b0, cen = 1'b0, cbad = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, spd = 8'h00, tdata;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [1:0] bresp, rresp, r, okp = 2'b11;
  logic [15:0] pos = 16'h0, cur = 16'h0, lim = 16'h0;
  logic [2:0] mv = 3'h0, ev = 3'h0, sel = 3'h0;
  logic [28:0] tid, fid;
  logic [63:0] frame;
  int frames, per, error_cnt = 0, samples_checked = 0, f;
  afb_status_framer #(.PERIOD_CYCLES(200), .OVL_CYCLES(20), .MS_CYCLES(10)) afb_status_framer_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .meas_pos(pos),
    .meas_cur(cur), .meas_speed(spd), .mv_extend(mv[0]), .mv_retract(mv[1]), .mv_saturated(mv[2]),
    .motor_driving(mdrv), .cmd_rx(crx), .cmd_enable(cen), .cmd_cur_limit(lim), .cmd_range_bad(cbad),
    .backdrive_evt(ev[0]), .stall_evt(ev[1]), .mem_bad_evt(ev[2]), .volt_ok_pin(okp[0]), .temp_ok_pin(okp[1]),
    .addr_sel_pin(sel), .motion_permit(permit), .motion_halt(halt), .tx_id(tid), .tx_data(tdata),
    .tx_valid(tvalid), .tx_last(tlast), .tx_ready(trdy));
  afb_can_sink afb_can_sink_i (.aclk(aclk), .aresetn(aresetn), .tx_id(tid), .tx_data(tdata), .tx_valid(tvalid),
    .tx_last(tlast), .tx_ready(trdy), .frame(frame), .fid(fid), .frames(frames), .per(per));
  // Free-running 100 MHz clock.
  always #5 aclk = ~aclk;
  // Expected frame, byte 0 in the low bits.
  function automatic logic [63:0] exp_frame(input logic [15:0] p, c, input logic [7:0] s, e, input logic [2:0] m);
    return {e, 5'h00, m, 8'h00, s, c, p};
  endfunction
  // Print counts and verdict, then stop.
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic tmo(input int n);
    if (n >= 60)
    begin
      error_cnt++;
      finish_test;
    end
  endtask
  // Bus write; address and data offered together.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (n = 0; n < 60 && !awr; n++) @(posedge aclk);
    awv <= 1'b0;
    wv <= 1'b0;
    for (n = n; n < 60 && !bv; n++) @(posedge aclk);
    r = bresp;
    brdy <= 1'b0;
    tmo(n);
    cyc(1);
  endtask
  // Bus read.
  task automatic rd(input logic [7:0] a);
    int n;
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (n = 0; n < 60 && !arr; n++) @(posedge aclk);
    arv <= 1'b0;
    for (n = n; n < 60 && !rv; n++) @(posedge aclk);
    d = rdat;
    r = rresp;
    rrdy <= 1'b0;
    tmo(n);
    cyc(1);
  endtask
  // One motion command frame.
  task automatic cmd(input logic en, bad);
    crx <= 1'b1;
    cen <= en;
    cbad <= bad;
    lim <= 16'd100;
    cyc(1);
    crx <= 1'b0;
    cyc(5);
  endtask
  task automatic pulse(input logic [2:0] m);
    ev <= m;
    cyc(1);
    ev <= 3'h0;
    cyc(5);
  endtask
  task automatic wait_frames(input int n);
    int k;
    f = frames;
    for (k = 0; k < 1000 && frames < f + n; k++) @(posedge aclk);
    tmo((k >= 1000) ? 60 : 0);
  endtask
  initial
  begin
    void'($urandom(32'h6e02));
    cyc(6);
    aresetn <= 1'b1;
    rd(TIMEOUT_OFS);
    `CHK(d, 32'h1388)
    rd(8'h40);
    `CHK(r, RESP_SLVERR)
    wr(8'h44, 32'h0);
    `CHK(r, RESP_SLVERR)
    for (int i = 0; i < 8; i++)
    begin
      sel <= 3'(i);
      cyc(10);
      rd(NODE_OFS);
      `CHK(d, {24'h0, NODE_ADDR_BASE + 8'(i)})
    end
    pulse(3'b101);
    $display("test setup done");
    for (int k = 0; k < 4; k++)
    begin
      pos <= 16'($urandom);
      cur <= 16'($urandom);
      spd <= 8'($urandom);
      mv <= 3'($urandom);
      sel <= 3'($urandom);
      wait_frames(2);
      `CHK(frame, exp_frame(pos, cur, spd, 8'h90, mv))
      `CHK(fid, {ID_HIGH, NODE_ADDR_BASE + {5'h0, sel}})
    end
    `CHK(per, 200)
    wr(ERR_CLR_OFS, 32'h91);
    rd(STATUS_OFS);
    `CHK(d[7:0], 8'h00)
    $display("test frames done");
    mv <= 3'h1;
    cur <= 16'd0;
    cmd(1'b1, 1'b0);
    cmd(1'b1, 1'b1);
    `CHK(permit, 1'b0)
    `CHK(halt, 1'b1)
    wr(ERR_CLR_OFS, 32'h1);
    cmd(1'b1, 1'b0);
    `CHK(permit, 1'b1)
    mdrv <= 1'b1;
    cur <= 16'd100;
    cyc(40);
    cur <= 16'd101;
    cyc(18);
    cur <= 16'd100;
    rd(STATUS_OFS);
    `CHK(d[1], 1'b0)
    cur <= 16'd101;
    cyc(25);
    cur <= 16'd0;
    rd(STATUS_OFS);
    `CHK(d[1], 1'b1)
    cmd(1'b1, 1'b0);
    `CHK(permit, 1'b0)
    cmd(1'b0, 1'b0);
    cmd(1'b1, 1'b0);
    `CHK(permit, 1'b1)
    pulse(3'b010);
    cmd(1'b1, 1'b0);
    `CHK(permit, 1'b0)
    cmd(1'b0, 1'b0);
    cmd(1'b1, 1'b0);
    `CHK(permit, 1'b1)
    mdrv <= 1'b0;
    $display("test motion done");
    for (int j = 0; j < 2; j++)
    begin
      okp <= j ? 2'b01 : 2'b10;
      cyc(30);
      `CHK(permit, 1'b0)
      `CHK(halt, 1'b0)
      rd(STATUS_OFS);
      `CHK(d[3:2], j ? 2'b10 : 2'b01)
      okp <= 2'b11;
      cyc(30);
      `CHK(permit, 1'b1)
    end
    wr(TIMEOUT_OFS, 32'h3);
    cyc(60);
    rd(STATUS_OFS);
    `CHK(d[5], 1'b1)
    cmd(1'b1, 1'b0);
    rd(STATUS_OFS);
    `CHK(d[5], 1'b0)
    wr(TIMEOUT_OFS, 32'h1388);
    wr(CTRL_OFS, 32'h0);
    cyc(100);
    f = frames;
    cyc(400);
    `CHK(frames, f)
    wr(CTRL_OFS, 32'h1);
    wait_frames(1);
    $display("test errors done");
    finish_test;
  end
  // Cut a hang short.
  initial
  begin
    cyc(90000);
    error_cnt++;
    finish_test;
  end
endmodule
